/* File: stage_model.sv */
// Power stage model: measures the on-time of each drive pulse
`timescale 1ns/1ps
`default_nettype none
module stage_model (
  input wire logic clock_i,
  input wire logic pwm_i,
  output logic [15:0] last_hi_o
);
  logic [15:0] hi_ff;
  // Coil is energised only while the drive is active; a pulse that never ends is not latched
  always_ff @(posedge clock_i) begin
    if (pwm_i) begin
      hi_ff <= hi_ff + 16'h0001;
    end else begin
      if (hi_ff != 16'h0000) begin
        last_hi_o <= hi_ff;
      end
      hi_ff <= 16'h0000;
    end
  end
endmodule : stage_model
`default_nettype wire

/* File: stepper_microstep_pwm.sv */
// Stepper drive PWM generator with linear duty map and microstep table
// Notes on behaviour
// - Output active at restart, inactive at compare
// - Period counter counts to limit, then zero
// - Duty is 8 high bits plus two low
// - Duty resolution at most ten bits
// - Maximum limit gives 256 steps per period
// - Non-microstep duty goes through linear map
// - Microstep values go to duty times two
// - Table holds one quarter sine wave
// - Default peak 250 bipolar, 125 unipolar
// - Speed request from ADC or serial byte
// - Run and stop compare raw request
// - Scale by constant, keep product high byte
// - Speed scaling constant is 32 bits
// - Step angle held in tenths of degree
// - New table lost at reset unless saved
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module stepper_microstep_pwm
  import stepper_pwm_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [7:0] adc_speed_i,
  input wire logic [7:0] serial_speed_i,
  output logic pwm_o,
  output logic polarity_o,
  output logic run_o,
  output logic [31:0] speed_scale_o,
  output logic [15:0] step_angle_o
);
  logic [2:0] ctrl_ff;
  logic [7:0] period_limit_ff;
  logic [7:0] min_duty_ff;
  logic [7:0] duty_scale_ff;
  logic [7:0] run_thr_ff;
  logic [7:0] stop_thr_ff;
  logic [31:0] speed_scale_ff;
  logic [15:0] step_angle_ff;
  logic [5:0] phase_ff;
  logic [31:0] rdata_ff;
  logic [7:0] cnt_ff;
  logic [1:0] sub_ff;
  logic [9:0] duty_ff;
  logic pwm_ff;
  logic pol_ff;
  run_state_t state_ff;
  run_state_t nxt_state;

  // Product high byte only; the 256 factor in the constant cancels here
  function automatic logic [7:0] scale_msb(input logic [7:0] req, input logic [7:0] k);
    logic [15:0] prod;
    prod = 16'(req) * 16'(k);
    return prod[15:8];
  endfunction : scale_msb

  // 255 spans the whole period, except at limit ff where it clamps to 1023 of 1024 clocks; 0 stays off
  function automatic logic [9:0] duty_map(input logic [7:0] level, input logic [7:0] limit);
    logic [10:0] span;
    logic [19:0] prod;
    span = {1'b0, limit, 2'b00} + 11'h004;
    prod = 20'(9'(level) + 9'h001) * 20'(span);
    if (level == 8'h00) return 10'h000;
    if (prod[19:8] > 12'(DUTY_MAX)) return DUTY_MAX;
    return prod[17:8];
  endfunction : duty_map

  wire sel_ctrl = addr_i == REG_CTRL;
  wire sel_period = addr_i == REG_PERIOD;
  wire sel_map = addr_i == REG_MAP;
  wire sel_thresh = addr_i == REG_THRESH;
  wire sel_speed = addr_i == REG_SPEED_SCALE;
  wire sel_angle = addr_i == REG_STEP_ANGLE;
  wire sel_phase = addr_i == REG_USTEP_PHASE;
  wire sel_table = addr_i == REG_TABLE;
  wire sel_status = addr_i == REG_STATUS;
  wire micro_mode = ctrl_ff[CTRL_MICRO];
  wire save_pulse = wr_i & sel_ctrl & wdata_i[CTRL_SAVE];
  wire table_wr = wr_i & sel_table;

  wire [7:0] speed_req = ctrl_ff[CTRL_SERIAL] ? serial_speed_i : adc_speed_i;
  wire [7:0] scaled = scale_msb(speed_req, duty_scale_ff);
  wire [8:0] level_sum = {1'b0, min_duty_ff} + {1'b0, scaled};
  wire [7:0] map_level = level_sum[8] ? 8'hff : level_sum[7:0];
  wire [9:0] map_duty = duty_map(map_level, period_limit_ff);

  // Mirror the quarter wave: odd quadrants read backwards, upper half flips polarity
  wire [3:0] tab_addr = phase_ff[4] ? ~phase_ff[3:0] : phase_ff[3:0];
  wire [7:0] tab_value;
  // Table byte is seven high duty bits plus the upper low bit
  wire [9:0] micro_duty = {1'b0, tab_value, 1'b0};
  wire [9:0] pending_duty = micro_mode ? micro_duty : map_duty;
  wire pending_pol = micro_mode & phase_ff[5];

  ustep_table u_table (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_i(table_wr),
    .waddr_i(wdata_i[TAB_INDEX_LSB +: 4]),
    .wdata_i(wdata_i[7:0]),
    .save_i(save_pulse),
    .unipolar_i(ctrl_ff[CTRL_UNIPOLAR]),
    .raddr_i(tab_addr),
    .rdata_o(tab_value)
  );

  // Ten-bit count: two prescaler bits below the period counter
  wire [9:0] cnt10 = {cnt_ff, sub_ff};
  wire step_done = sub_ff == PRESCALE_LAST;
  wire restart = step_done & (cnt_ff == period_limit_ff);
  wire [1:0] nxt_sub = sub_ff + 2'h1;
  wire [7:0] cnt_inc = cnt_ff + 8'h01;
  wire [7:0] nxt_cnt = restart ? 8'h00 : (step_done ? cnt_inc : cnt_ff);
  wire [9:0] nxt_duty = restart ? pending_duty : duty_ff;
  wire nxt_pwm = {nxt_cnt, nxt_sub} < nxt_duty;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_ff <= 8'h00;
      sub_ff <= 2'h0;
      duty_ff <= 10'h000;
      pwm_ff <= 1'b0;
      pol_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sub_ff <= nxt_sub;
      duty_ff <= nxt_duty;
      pwm_ff <= nxt_pwm;
      pol_ff <= restart ? pending_pol : pol_ff;
    end
  end

  // Hysteresis between run and stop on the raw request byte
  always_comb begin
    case (state_ff)
      ST_STOP: nxt_state = (speed_req > run_thr_ff) ? ST_RUN : ST_STOP;
      ST_RUN: nxt_state = (speed_req < stop_thr_ff) ? ST_STOP : ST_RUN;
      default: nxt_state = ST_STOP;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff <= ST_STOP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_ff <= 3'h0;
      period_limit_ff <= PERIOD_LIMIT_RST;
      min_duty_ff <= MIN_DUTY_RST;
      duty_scale_ff <= DUTY_SCALE_RST;
      run_thr_ff <= RUN_THR_RST;
      stop_thr_ff <= STOP_THR_RST;
      speed_scale_ff <= SPEED_SCALE_RST;
      step_angle_ff <= STEP_ANGLE_RST;
      phase_ff <= 6'h00;
    end else if (wr_i) begin
      if (sel_ctrl) ctrl_ff <= wdata_i[2:0];
      if (sel_period) period_limit_ff <= wdata_i[7:0];
      if (sel_map) min_duty_ff <= wdata_i[7:0];
      if (sel_map) duty_scale_ff <= wdata_i[MAP_SCALE_LSB +: 8];
      if (sel_thresh) run_thr_ff <= wdata_i[7:0];
      if (sel_thresh) stop_thr_ff <= wdata_i[THR_STOP_LSB +: 8];
      if (sel_speed) speed_scale_ff <= wdata_i;
      if (sel_angle) step_angle_ff <= wdata_i[15:0];
      if (sel_phase) phase_ff <= wdata_i[5:0];
    end
  end

  wire [31:0] status_word = {5'h00, pwm_ff, pol_ff, state_ff == ST_RUN, 6'h00, duty_ff, cnt_ff};
  wire [31:0] rd_word =
    sel_ctrl ? {29'h0, ctrl_ff} :
    sel_period ? {24'h0, period_limit_ff} :
    sel_map ? {16'h0, duty_scale_ff, min_duty_ff} :
    sel_thresh ? {16'h0, stop_thr_ff, run_thr_ff} :
    sel_speed ? speed_scale_ff :
    sel_angle ? {16'h0, step_angle_ff} :
    sel_phase ? {26'h0, phase_ff} :
    sel_table ? {24'h0, tab_value} :
    sel_status ? status_word : 32'h0;

  // Read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= rd_i ? rd_word : 32'h0;
    end
  end

  assign rdata_o = rdata_ff;
  assign pwm_o = pwm_ff;
  assign polarity_o = pol_ff;
  assign run_o = state_ff == ST_RUN;
  assign speed_scale_o = speed_scale_ff;
  assign step_angle_o = step_angle_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_wrap;
    restart |=> cnt_ff == 8'h00 && sub_ff == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not restart");

  property p_set;
    restart && pending_duty != 10'h000 |=> pwm_ff;
  endproperty
  a_set: assert property (p_set) else $error("output not active at restart");

  property p_compare;
    pwm_ff == (cnt10 < duty_ff);
  endproperty
  a_compare: assert property (p_compare) else $error("output does not match compare");

  property p_hold;
    !restart |=> duty_ff == $past(duty_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("duty changed mid period");

  property p_sub;
    sub_ff == 2'h0 |=> sub_ff == 2'h1 ##1 sub_ff == 2'h2 ##1 sub_ff == 2'h3;
  endproperty
  a_sub: assert property (p_sub) else $error("low count bits out of order");

  property p_run;
    state_ff == ST_STOP && speed_req > run_thr_ff |=> run_o;
  endproperty
  a_run: assert property (p_run) else $error("run threshold missed");

  property p_stop;
    state_ff == ST_RUN && speed_req < stop_thr_ff |=> !run_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop threshold missed");

  property p_map_full;
    !micro_mode && map_level == 8'hff && period_limit_ff != 8'hff
      |-> map_duty == 10'({period_limit_ff, 2'b00} + 10'h004);
  endproperty
  a_map_full: assert property (p_map_full) else $error("full request not full duty");

  property p_micro;
    micro_mode && restart |=> duty_ff == {1'b0, $past(tab_value), 1'b0};
  endproperty
  a_micro: assert property (p_micro) else $error("microstep value altered");

  property p_count_step;
    step_done && !restart |=> cnt_ff == $past(cnt_ff) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("period counter did not advance");

  property p_count_hold;
    !step_done |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("period counter moved between steps");

  property p_sub_wrap;
    sub_ff == 2'h3 |=> sub_ff == 2'h0;
  endproperty
  a_sub_wrap: assert property (p_sub_wrap) else $error("low count bits did not wrap");

  property p_zero_duty;
    duty_ff == 10'h000 |-> !pwm_ff;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("output active with zero duty");

  property p_restart_low;
    restart && pending_duty == 10'h000 |=> !pwm_ff;
  endproperty
  a_restart_low: assert property (p_restart_low) else $error("zero duty period started active");

  property p_pol_hold;
    !restart |=> polarity_o == $past(polarity_o);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("polarity changed mid period");

  property p_pol_lin;
    restart && !micro_mode |=> !polarity_o;
  endproperty
  a_pol_lin: assert property (p_pol_lin) else $error("polarity set outside microstepping");

  property p_pol_micro;
    restart && micro_mode |=> polarity_o == $past(phase_ff[5]);
  endproperty
  a_pol_micro: assert property (p_pol_micro) else $error("polarity does not follow phase");

  property p_map_zero;
    !micro_mode && map_level == 8'h00 |-> map_duty == 10'h000;
  endproperty
  a_map_zero: assert property (p_map_zero) else $error("zero level gave nonzero duty");

  property p_map_max;
    !micro_mode && map_level == 8'hff && period_limit_ff == 8'hff |-> map_duty == DUTY_MAX;
  endproperty
  a_map_max: assert property (p_map_max) else $error("full level at longest period not clamped");

  property p_scale_bound;
    scaled <= speed_req;
  endproperty
  a_scale_bound: assert property (p_scale_bound) else $error("scaled request above raw request");

  property p_level_floor;
    map_level >= min_duty_ff;
  endproperty
  a_level_floor: assert property (p_level_floor) else $error("map level below minimum duty");

  property p_speed_write;
    wr_i && sel_speed |=> speed_scale_o == $past(wdata_i);
  endproperty
  a_speed_write: assert property (p_speed_write) else $error("speed constant not stored whole");

  property p_angle_write;
    wr_i && sel_angle |=> step_angle_o == $past(wdata_i[15:0]);
  endproperty
  a_angle_write: assert property (p_angle_write) else $error("step angle not stored");

  property p_run_hold;
    state_ff == ST_RUN && speed_req >= stop_thr_ff |=> run_o;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("stopped above stop threshold");

  property p_stop_hold;
    state_ff == ST_STOP && speed_req <= run_thr_ff |=> !run_o;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("started at or below run threshold");

  c_restart: cover property (restart ##1 pwm_ff);
  c_run: cover property (state_ff == ST_STOP ##1 state_ff == ST_RUN);
  c_micro: cover property (micro_mode && restart && phase_ff[5]);
  c_stop: cover property (state_ff == ST_RUN ##1 state_ff == ST_STOP);
  c_full_map: cover property (!micro_mode && map_level == 8'hff && restart);
endmodule : stepper_microstep_pwm
`default_nettype wire

/* File: stepper_microstep_pwm_bench.sv */
// Self-checking bench for the stepper PWM generator
`timescale 1ns/1ps
`default_nettype none
module stepper_microstep_pwm_bench;
  import stepper_pwm_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] adc_speed_i = 8'h00;
  logic [7:0] serial_speed_i = 8'h00;
  logic [31:0] rdata_o;
  logic [31:0] speed_scale_o;
  logic [15:0] step_angle_o;
  logic [15:0] last_hi;
  logic pwm_o;
  logic polarity_o;
  logic run_o;
  int n_errors = 0;
  int num_checks = 0;
  always #20 clock_i = ~clock_i;
  stepper_microstep_pwm DUT (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_speed_i(adc_speed_i),
    .serial_speed_i(serial_speed_i), .pwm_o(pwm_o), .polarity_o(polarity_o), .run_o(run_o),
    .speed_scale_o(speed_scale_o), .step_angle_o(step_angle_o));
  stage_model stage (.clock_i(clock_i), .pwm_i(pwm_o), .last_hi_o(last_hi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : reg_wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd_chk
  task automatic reset_seq();
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
  endtask : reset_seq
  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic t_reset_values();
    rd_chk(REG_PERIOD, 32'h0000_00ff);
    rd_chk(REG_MAP, 32'h0000_ff00);
    rd_chk(REG_THRESH, 32'h0000_0508);
    rd_chk(4'h9, 32'h0000_0000);
    chk(speed_scale_o, 32'h0000_0000);
    chk({16'h0000, step_angle_o}, 32'h0000_0012);
  endtask : t_reset_values
  task automatic t_consts();
    reg_wr(REG_SPEED_SCALE, 32'hdead_beef);
    reg_wr(REG_STEP_ANGLE, 32'h0000_0009);
    repeat (2) @(posedge clock_i);
    chk(speed_scale_o, 32'hdead_beef);
    chk({16'h0000, step_angle_o}, 32'h0000_0009);
  endtask : t_consts
  task automatic t_run();
    reg_wr(REG_CTRL, 32'h0000_0000);
    adc_speed_i <= 8'h09;
    repeat (4) @(posedge clock_i);
    chk({31'h0, run_o}, 32'h1);
    adc_speed_i <= 8'h05;
    repeat (4) @(posedge clock_i);
    chk({31'h0, run_o}, 32'h1);
    adc_speed_i <= 8'h04;
    repeat (4) @(posedge clock_i);
    chk({31'h0, run_o}, 32'h0);
    reg_wr(REG_THRESH, 32'h0000_1020);
    adc_speed_i <= 8'h20;
    repeat (4) @(posedge clock_i);
    chk({31'h0, run_o}, 32'h0);
    adc_speed_i <= 8'h21;
    repeat (4) @(posedge clock_i);
    chk({31'h0, run_o}, 32'h1);
  endtask : t_run
  task automatic t_linear();
    int bad;
    bad = 0;
    // Limit ff: 1024 clocks a period, duty = (min + req*scale/256 + 1) * 4
    reg_wr(REG_CTRL, 32'h0000_0000);
    reg_wr(REG_PERIOD, 32'h0000_00ff);
    reg_wr(REG_MAP, 32'h0000_8010);
    adc_speed_i <= 8'h40;
    repeat (3072) @(posedge clock_i);
    chk({16'h0, last_hi}, 32'd196);
    reg_wr(REG_MAP, 32'h0000_ffff);
    repeat (3072) @(posedge clock_i);
    chk({16'h0, last_hi}, 32'd1023);
    // Serial source with a 64-step period: duty equals level plus one
    // A shorter limit may be written past the count, which then runs round once before restarting
    reg_wr(REG_CTRL, 32'h0000_0002);
    reg_wr(REG_MAP, 32'h0000_8010);
    reg_wr(REG_PERIOD, 32'h0000_003f);
    serial_speed_i <= 8'h20;
    repeat (1600) @(posedge clock_i);
    chk({16'h0, last_hi}, 32'd33);
    // Saturated level with a short period keeps the drive on throughout
    reg_wr(REG_MAP, 32'h0000_ffff);
    repeat (600) @(posedge clock_i);
    for (int i = 0; i < 300; i++) begin
      @(posedge clock_i);
      if (pwm_o !== 1'b1) bad++;
    end
    chk(bad, 0);
  endtask : t_linear
  task automatic t_micro();
    int bad;
    bad = 0;
    reg_wr(REG_CTRL, 32'h0000_0001);
    reg_wr(REG_PERIOD, 32'h0000_007c);
    reg_wr(REG_USTEP_PHASE, 32'h0000_0000);
    reg_wr(REG_TABLE, 32'h0000_0040);
    rd_chk(REG_TABLE, 32'h0000_0040);
    repeat (1500) @(posedge clock_i);
    chk({16'h0, last_hi}, 32'd128);
    reg_wr(REG_TABLE, 32'h0000_00fa);
    repeat (1000) @(posedge clock_i);
    for (int i = 0; i < 600; i++) begin
      @(posedge clock_i);
      if (pwm_o !== 1'b1) bad++;
    end
    chk(bad, 0);
    chk({31'h0, polarity_o}, 32'h0);
    reg_wr(REG_USTEP_PHASE, 32'h0000_0020);
    repeat (600) @(posedge clock_i);
    chk({31'h0, polarity_o}, 32'h1);
  endtask : t_micro
  task automatic t_table();
    reset_seq();
    reg_wr(REG_USTEP_PHASE, 32'h0000_000f);
    rd_chk(REG_TABLE, 32'h0000_00fa);
    reg_wr(REG_USTEP_PHASE, 32'h0000_0010);
    rd_chk(REG_TABLE, 32'h0000_00fa);
    reg_wr(REG_CTRL, 32'h0000_0004);
    rd_chk(REG_TABLE, 32'h0000_007d);
    reg_wr(REG_CTRL, 32'h0000_0000);
    reg_wr(REG_USTEP_PHASE, 32'h0000_000f);
    reg_wr(REG_TABLE, 32'h0000_0f11);
    rd_chk(REG_TABLE, 32'h0000_0011);
    reset_seq();
    reg_wr(REG_USTEP_PHASE, 32'h0000_000f);
    rd_chk(REG_TABLE, 32'h0000_00fa);
    reg_wr(REG_TABLE, 32'h0000_0f22);
    reg_wr(REG_CTRL, 32'h0000_0008);
    reset_seq();
    reg_wr(REG_USTEP_PHASE, 32'h0000_000f);
    rd_chk(REG_TABLE, 32'h0000_0022);
  endtask : t_table
  // Budget well above the roughly 12.5k cycles the tests need
  initial begin
    repeat (60000) @(posedge clock_i);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset_values();
    t_consts();
    t_run();
    t_linear();
    t_micro();
    t_table();
    test_done();
  end
endmodule : stepper_microstep_pwm_bench
`default_nettype wire

/* File: stepper_pwm_pkg.sv */
// Constants shared by the stepper PWM generator and its microstep table
package stepper_pwm_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PERIOD = 4'h1;
  localparam logic [3:0] REG_MAP = 4'h2;
  localparam logic [3:0] REG_THRESH = 4'h3;
  localparam logic [3:0] REG_SPEED_SCALE = 4'h4;
  localparam logic [3:0] REG_STEP_ANGLE = 4'h5;
  localparam logic [3:0] REG_USTEP_PHASE = 4'h6;
  localparam logic [3:0] REG_TABLE = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Control register bits
  localparam int CTRL_MICRO = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int CTRL_UNIPOLAR = 2;
  localparam int CTRL_SAVE = 3;
  // Field positions
  localparam int MAP_SCALE_LSB = 8;
  localparam int THR_STOP_LSB = 8;
  localparam int TAB_INDEX_LSB = 8;
  localparam int ST_DUTY_LSB = 8;
  localparam int ST_RUN_BIT = 24;
  localparam int ST_POL_BIT = 25;
  localparam int ST_PWM_BIT = 26;
  // Values after reset
  localparam logic [7:0] PERIOD_LIMIT_RST = 8'hff;
  localparam logic [7:0] MIN_DUTY_RST = 8'h00;
  localparam logic [7:0] DUTY_SCALE_RST = 8'hff;
  localparam logic [7:0] RUN_THR_RST = 8'h08;
  localparam logic [7:0] STOP_THR_RST = 8'h05;
  localparam logic [31:0] SPEED_SCALE_RST = 32'h0000_0000;
  localparam logic [15:0] STEP_ANGLE_RST = 16'h0012;
  // Prescaler: four clocks per period counter step
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [9:0] DUTY_MAX = 10'h3ff;
  // Run state machine
  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;
endpackage : stepper_pwm_pkg

/* File: ustep_table.sv */
// Quarter-wave microstep table: volatile copy, saved copy and default sine
`timescale 1ns/1ps
`default_nettype none
module ustep_table
  import stepper_pwm_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic wr_i,
  input wire logic [3:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic save_i,
  input wire logic unipolar_i,
  input wire logic [3:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] ram [16];
  logic [15:0] ram_valid_ff;
  logic [7:0] nv_mem [16];
  // Saved copy survives reset on purpose, so its flag has no reset
  logic nv_valid_ff = 1'b0;

  // Full-scale sine magnitudes, peak 250; unipolar halves to peak 125
  function automatic logic [7:0] sine_default(input logic [3:0] k, input logic half);
    logic [7:0] full;
    case (k)
      4'h0: full = 8'h19;
      4'h1: full = 8'h31;
      4'h2: full = 8'h49;
      4'h3: full = 8'h60;
      4'h4: full = 8'h76;
      4'h5: full = 8'h8b;
      4'h6: full = 8'h9f;
      4'h7: full = 8'hb1;
      4'h8: full = 8'hc1;
      4'h9: full = 8'hd0;
      4'ha: full = 8'hdd;
      4'hb: full = 8'he7;
      4'hc: full = 8'hef;
      4'hd: full = 8'hf5;
      4'he: full = 8'hf9;
      default: full = 8'hfa;
    endcase
    return half ? 8'((9'(full) + 9'h001) >> 1) : full;
  endfunction : sine_default

  function automatic logic [7:0] entry(input logic [3:0] k);
    if (ram_valid_ff[k]) return ram[k];
    if (nv_valid_ff) return nv_mem[k];
    return sine_default(k, unipolar_i);
  endfunction : entry

  always_ff @(posedge clock_i) begin
    if (wr_i) begin
      ram[waddr_i] <= wdata_i;
    end
  end

  // Reset forgets every volatile entry
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ram_valid_ff <= 16'h0000;
    end else if (wr_i) begin
      ram_valid_ff[waddr_i] <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (save_i) begin
      for (int i = 0; i < 16; i++) begin
        nv_mem[i] <= entry(4'(i));
      end
      nv_valid_ff <= 1'b1;
    end
  end

  // A continuous read only wakes on function arguments, so the stored words are read outside it
  wire [7:0] ram_word = ram[raddr_i];
  wire [7:0] nv_word = nv_mem[raddr_i];
  wire [7:0] def_word = sine_default(raddr_i, unipolar_i);
  assign rdata_o = ram_valid_ff[raddr_i] ? ram_word : (nv_valid_ff ? nv_word : def_word);
endmodule : ustep_table
`default_nettype wire
